// [verilog/xor_skip_pkg.sv]
`default_nettype none
package xor_skip_pkg;
  // quarter phases of one instruction cycle
  localparam logic [1:0] QP_1 = 2'h0;
  localparam logic [1:0] QP_2 = 2'h1;
  localparam logic [1:0] QP_3 = 2'h2;
  localparam logic [1:0] QP_4 = 2'h3;
  // opcode masks and patterns
  localparam logic [15:0] TWR_MASK   = 16'hFFFC;
  localparam logic [15:0] TWR_PAT    = 16'h000C;
  localparam logic [15:0] TSTSK_MASK = 16'hFE00;
  localparam logic [15:0] TSTSK_PAT  = 16'h6600;
  localparam logic [15:0] XORL_MASK  = 16'hFF00;
  localparam logic [15:0] XORL_PAT   = 16'h0A00;
  localparam logic [15:0] XORR_MASK  = 16'hFC00;
  localparam logic [15:0] XORR_PAT   = 16'h1800;
  // field positions
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  // access bank split: low half maps to bank 0, high half to the top bank
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam int PTR_W = 21;
  localparam int HOLD_N = 8;
  localparam int HOLD_SEL_W = 3;
  // table write pointer modes (low two opcode bits)
  localparam logic [1:0] TW_KEEP = 2'h0;
  localparam logic [1:0] TW_POST_INC = 2'h1;
  localparam logic [1:0] TW_POST_DEC = 2'h2;
  localparam logic [1:0] TW_PRE_INC = 2'h3;
  localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
  localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] IR_RST = 16'h0000;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_TWR   = 3'b001,
    OP_TSTSK = 3'b010,
    OP_XORL  = 3'b011,
    OP_XORR  = 3'b100
  } op_t;

  typedef enum logic [1:0] {
    ST_EXEC   = 2'b00,
    ST_TWR2   = 2'b01,
    ST_SKIP1  = 2'b10,
    ST_SKIP2  = 2'b11
  } cyc_state_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [7:0]  data;
  } reg_wr_t;
endpackage
`default_nettype wire

// [verilog/table_write_skip_xor_exec.sv]
// Behaviour
// - table write takes second cycle, Q2 read, Q4 write
// - post-increment writes first, then bumps pointer
// - pre-increment bumps pointer, then writes holding register
// - test-skip decoded by upper pattern, bank bit, address
// - test-skip compares with zero, no writes, no flags
// - zero result discards prefetched word, one idle cycle
// - skipped two-word instruction costs two idle cycles
// - clear bank bit forces access bank, else bank select
// - xor literal decoded, W xor literal into W
// - both xors update only negative and zero flags
// - dest clear writes W, set writes the register
// - xor register completes in one cycle, writes at Q4
// - pointer low three bits select one of eight holding
// - pointer is 21 bits wide
`default_nettype none
module table_write_skip_xor_exec
  import xor_skip_pkg::*;
(
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_srst,
  input  wire logic [15:0]              i_instr,
  input  wire logic                     i_next_two_word,
  input  wire logic [3:0]               i_bank_select_reg,
  input  wire logic [7:0]               i_rd_data,
  input  wire logic [7:0]               i_table_latch,
  input  wire logic                     i_ptr_load,
  input  wire logic [PTR_W-1:0]         i_ptr_data,
  output logic                          o_instr_take,
  output logic                          o_discard,
  output logic [1:0]                    o_quarter,
  output logic [11:0]                   o_rd_addr,
  output reg_wr_t                       o_wr,
  output logic [7:0]                    o_w,
  output logic                          o_flag_n,
  output logic                          o_flag_z,
  output logic [PTR_W-1:0]              o_table_pointer,
  output logic [HOLD_N-1:0][7:0]        o_holding
);
  logic [1:0]             quarter_q;
  cyc_state_t             state_q;
  logic [15:0]            ir_q;
  logic [7:0]             opnd_q;
  logic [7:0]             latch_q;
  logic                   two_q;
  logic [7:0]             w_q;
  logic                   n_q;
  logic                   z_q;
  logic [PTR_W-1:0]       ptr_q;
  logic [HOLD_N-1:0][7:0] hold_q;
  reg_wr_t                wr_q;
  op_t                    op;
  logic [7:0]             xor_res;
  logic                   take;
  logic                   exec;

  // opcode classification of the latched word
  always_comb begin
    if ((ir_q & TWR_MASK) == TWR_PAT) begin
      op = OP_TWR;
    end else if ((ir_q & TSTSK_MASK) == TSTSK_PAT) begin
      op = OP_TSTSK;
    end else if ((ir_q & XORL_MASK) == XORL_PAT) begin
      op = OP_XORL;
    end else if ((ir_q & XORR_MASK) == XORR_PAT) begin
      op = OP_XORR;
    end else begin
      op = OP_NONE;
    end
  end

  // literal form uses the instruction byte, register form the fetched operand
  assign xor_res = w_q ^ ((op == OP_XORL) ? ir_q[7:0] : opnd_q);
  assign exec = (state_q == ST_EXEC);
  assign take = (quarter_q == QP_1) && (state_q != ST_TWR2);
  assign o_instr_take = take;
  assign o_discard = take && (state_q != ST_EXEC);
  assign o_quarter = quarter_q;
  assign o_wr = wr_q;
  assign o_w = w_q;
  assign o_flag_n = n_q;
  assign o_flag_z = z_q;
  assign o_table_pointer = ptr_q;
  assign o_holding = hold_q;

  // bank choice: the bank bit low ignores the bank select register
  always_comb begin
    if (ir_q[BANK_BIT]) begin
      o_rd_addr = {i_bank_select_reg, ir_q[7:0]};
    end else if (ir_q[7:0] < ACC_SPLIT) begin
      o_rd_addr = {ACC_LO_BANK, ir_q[7:0]};
    end else begin
      o_rd_addr = {ACC_HI_BANK, ir_q[7:0]};
    end
  end

  // free-running quarter phase counter
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      quarter_q <= QP_1;
    end else begin
      quarter_q <= quarter_q + 2'h1;
    end
  end

  // instruction latch; words taken during idle cycles are thrown away
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ir_q <= IR_RST;
    end else if (take && exec) begin
      ir_q <= i_instr;
    end else if (take) begin
      ir_q <= IR_RST;
    end
  end

  // operand read in Q2, table latch read in Q2 of the second cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      opnd_q <= BYTE_ZERO;
      latch_q <= BYTE_ZERO;
    end else if (quarter_q == QP_2) begin
      if (exec) begin
        opnd_q <= i_rd_data;
      end
      if (state_q == ST_TWR2) begin
        latch_q <= i_table_latch;
      end
    end
  end

  // cycle sequencer, advanced at the end of Q4
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_q <= ST_EXEC;
      two_q <= 1'b0;
    end else if (quarter_q == QP_4) begin
      case (state_q)
        ST_EXEC: begin
          if (op == OP_TWR) begin
            state_q <= ST_TWR2;
          end else if (op == OP_TSTSK && opnd_q == BYTE_ZERO) begin
            state_q <= ST_SKIP1;
            two_q <= i_next_two_word;
          end
        end
        ST_SKIP1: begin
          state_q <= two_q ? ST_SKIP2 : ST_EXEC;
          two_q <= 1'b0;
        end
        default: begin
          state_q <= ST_EXEC;
        end
      endcase
    end
  end

  // register write port: valid through Q4 only, never for the test-skip
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wr_q <= '0;
    end else if (quarter_q == QP_3 && exec && op == OP_XORR && ir_q[DEST_BIT]) begin
      wr_q <= '{en: 1'b1, addr: o_rd_addr, data: xor_res};
    end else begin
      wr_q <= '0;
    end
  end

  // working register and flags; carry group lives elsewhere and is untouched
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      w_q <= BYTE_ZERO;
      n_q <= 1'b0;
      z_q <= 1'b0;
    end else if (quarter_q == QP_4 && exec && (op == OP_XORL || op == OP_XORR)) begin
      if (op == OP_XORL || !ir_q[DEST_BIT]) begin
        w_q <= xor_res;
      end
      n_q <= xor_res[7];
      z_q <= (xor_res == BYTE_ZERO);
    end
  end

  // table pointer: pre-increment in Q2, post forms in Q4 after the write
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ptr_q <= PTR_RST;
    end else if (state_q == ST_TWR2 && quarter_q == QP_2 && ir_q[1:0] == TW_PRE_INC) begin
      ptr_q <= ptr_q + PTR_ONE;
    end else if (state_q == ST_TWR2 && quarter_q == QP_4 && ir_q[1:0] == TW_POST_INC) begin
      ptr_q <= ptr_q + PTR_ONE;
    end else if (state_q == ST_TWR2 && quarter_q == QP_4 && ir_q[1:0] == TW_POST_DEC) begin
      ptr_q <= ptr_q - PTR_ONE;
    end else if (i_ptr_load) begin
      ptr_q <= i_ptr_data;
    end
  end

  // eight holding registers, one written per table write
  for (genvar g = 0; g < HOLD_N; g++) begin : g_hold
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        hold_q[g] <= BYTE_ZERO;
      end else if (state_q == ST_TWR2 && quarter_q == QP_4
                   && ptr_q[HOLD_SEL_W-1:0] == HOLD_SEL_W'(g)) begin
        hold_q[g] <= latch_q;
      end
    end
  end

  // checks
  twr_second_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (exec && quarter_q == QP_4 && op == OP_TWR) |=> state_q == ST_TWR2 [*4])
    else $error("table write did not take a second cycle");
  hold_when_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (hold_q != $past(hold_q)) |-> ($past(state_q) == ST_TWR2 && $past(quarter_q) == QP_4))
    else $error("holding register changed outside table write Q4");
  post_inc_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (state_q == ST_TWR2 && quarter_q == QP_4 && ir_q[1:0] == TW_POST_INC)
    |=> ptr_q == $past(ptr_q) + PTR_ONE && hold_q[$past(ptr_q[2:0])] == $past(latch_q))
    else $error("post-increment table write wrong");
  pre_inc_a: assert property (@(posedge i_clk_sys) disable iff (i_srst || i_ptr_load)
    (state_q == ST_TWR2 && quarter_q == QP_1 && ir_q[1:0] == TW_PRE_INC)
    |-> ##4 hold_q[$past(ptr_q[2:0], 4) + 3'h1] == $past(latch_q))
    else $error("pre-increment table write wrong");
  skip_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (exec && quarter_q == QP_4 && op == OP_TSTSK && opnd_q == BYTE_ZERO && !i_next_two_word)
    |=> o_discard ##4 !o_discard)
    else $error("skip did not discard the prefetched word");
  skip_two_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (exec && quarter_q == QP_4 && op == OP_TSTSK && opnd_q == BYTE_ZERO && i_next_two_word)
    |=> o_discard ##4 o_discard ##4 !o_discard)
    else $error("two-word skip did not idle two cycles");
  tst_nowrite_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (exec && op == OP_TSTSK) |=> !wr_q.en && $stable(w_q) && $stable(z_q))
    else $error("test-skip changed state");
  bank_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !ir_q[BANK_BIT] |-> o_rd_addr[11:8] == (ir_q[7] ? ACC_HI_BANK : ACC_LO_BANK))
    else $error("access bank not forced");
  xorl_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (exec && quarter_q == QP_4 && op == OP_XORL)
    |=> w_q == ($past(w_q) ^ $past(ir_q[7:0])) && z_q == (w_q == BYTE_ZERO) && n_q == w_q[7])
    else $error("xor literal result or flags wrong");
  xorr_dest_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (exec && quarter_q == QP_3 && op == OP_XORR && ir_q[DEST_BIT])
    |=> wr_q.en && wr_q.data == ($past(w_q) ^ opnd_q) ##1 !wr_q.en && $stable(w_q))
    else $error("xor register destination wrong");
  xor_cov_c: cover property (@(posedge i_clk_sys) exec && quarter_q == QP_4 && op == OP_XORR);
  skip2_cov_c: cover property (@(posedge i_clk_sys) state_q == ST_SKIP2);
  pre_cov_c: cover property (@(posedge i_clk_sys)
    state_q == ST_TWR2 && quarter_q == QP_4 && ir_q[1:0] == TW_PRE_INC);
endmodule
`default_nettype wire

// [sim/tb_table_write_skip_xor_exec.sv]
`default_nettype none
module tb_table_write_skip_xor_exec
  import xor_skip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk;
  logic                   srst;
  logic [15:0]            instr;
  logic                   two_word;
  logic [3:0]             bank_sel;
  logic [7:0]             rd;
  logic [7:0]             latch;
  logic                   ptr_load;
  logic [PTR_W-1:0]       ptr_data;
  logic                   take;
  logic                   disc;
  logic [1:0]             quarter;
  logic [11:0]            rd_addr;
  reg_wr_t                wr;
  logic [7:0]             w;
  logic                   fn;
  logic                   fz;
  logic [PTR_W-1:0]       ptr;
  logic [HOLD_N-1:0][7:0] hold;
  logic                   s_take;
  logic                   s_disc;
  logic [11:0]            s_addr;
  reg_wr_t                s_wr;
  int                     miscompares = 0;
  int                     n_compared = 0;

  table_write_skip_xor_exec table_write_skip_xor_exec_i (
    .i_clk_sys(clk), .i_srst(srst), .i_instr(instr), .i_next_two_word(two_word),
    .i_bank_select_reg(bank_sel), .i_rd_data(rd), .i_table_latch(latch),
    .i_ptr_load(ptr_load), .i_ptr_data(ptr_data), .o_instr_take(take),
    .o_discard(disc), .o_quarter(quarter), .o_rd_addr(rd_addr), .o_wr(wr), .o_w(w),
    .o_flag_n(fn), .o_flag_z(fz), .o_table_pointer(ptr), .o_holding(hold));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one instruction cycle from the Q1 falling edge; snapshots taken where each output stands
  task automatic cyc(input logic [15:0] word);
    instr = word;
    s_take = take;
    s_disc = disc;
    @(negedge clk);
    s_addr = rd_addr;
    repeat (2) @(negedge clk);
    s_wr = wr;
    @(negedge clk);
  endtask

  task automatic t_xor_literal();
    cyc(16'h0AB5);
    chk({11'h000, w, fn, fz}, {11'h000, 8'hB5, 2'h2});
    cyc(16'h0AB5);
    chk({11'h000, w, fn, fz}, {11'h000, 8'h00, 2'h1});
    cyc(16'h0AB5);
    $display("xor literal test done");
  endtask

  // bank select set to 3 so that a forced access bank is visible
  task automatic t_xor_register();
    bank_sel = 4'h3;
    rd = 8'hAF;
    cyc(16'h1A10);
    chk({9'h000, s_addr}, {9'h000, ACC_LO_BANK, 8'h10});
    chk({s_wr.en, s_wr.addr, s_wr.data}, {1'b1, ACC_LO_BANK, 8'h10, 8'h1A});
    chk({11'h000, w, fn, fz}, {11'h000, 8'hB5, 2'h0});
    rd = 8'h35;
    cyc(16'h1990);
    chk({9'h000, s_addr}, {9'h000, 4'h3, 8'h90});
    chk({10'h000, s_wr.en, w, fn, fz}, {10'h000, 1'b0, 8'h80, 2'h2});
    rd = 8'h80;
    cyc(16'h1890);
    chk({9'h000, s_addr}, {9'h000, ACC_HI_BANK, 8'h90});
    chk({10'h000, s_wr.en, w, fn, fz}, {10'h000, 1'b0, 8'h00, 2'h1});
    $display("xor register test done");
  endtask

  // prefetched words are xor literals, so a missed discard shows up in W
  task automatic t_test_skip();
    cyc(16'h0A81);
    rd = 8'h00;
    cyc(16'h6720);
    chk({9'h000, s_addr}, {9'h000, 4'h3, 8'h20});
    chk({10'h000, s_wr.en, w, fn, fz}, {10'h000, 1'b0, 8'h81, 2'h2});
    cyc(16'h0AFF);
    chk({10'h000, s_disc, w, fn, fz}, {10'h000, 1'b1, 8'h81, 2'h2});
    cyc(16'h0A01);
    chk({12'h000, s_disc, w}, {12'h000, 1'b0, 8'h80});
    two_word = 1'b1;
    cyc(16'h6605);
    two_word = 1'b0;
    chk({9'h000, s_addr}, {9'h000, ACC_LO_BANK, 8'h05});
    cyc(16'h0AFF);
    chk({20'h00000, s_disc}, 21'h000001);
    cyc(16'h0AFF);
    chk({12'h000, s_disc, w}, {12'h000, 1'b1, 8'h80});
    cyc(16'h0A80);
    chk({12'h000, s_disc, w}, {12'h000, 1'b0, 8'h00});
    rd = 8'h01;
    cyc(16'h6720);
    cyc(16'h0A3C);
    chk({12'h000, s_disc, w}, {12'h000, 1'b0, 8'h3C});
    $display("test and skip test done");
  endtask

  // the latch only holds the right value from the second cycle on
  task automatic tbl(input logic [1:0] mode, input logic [7:0] lat);
    latch = ~lat;
    cyc({14'h0003, mode});
    latch = lat;
    cyc(16'h0000);
    chk({20'h00000, s_take}, 21'h000000);
  endtask

  task automatic load_ptr(input logic [PTR_W-1:0] val);
    ptr_data = val;
    ptr_load = 1'b1;
    cyc(16'h0000);
    ptr_load = 1'b0;
    chk(ptr, val);
  endtask

  task automatic t_table_write();
    load_ptr(21'h00A356);
    tbl(TW_POST_INC, 8'h55);
    chk({13'h0000, hold[6]}, {13'h0000, 8'h55});
    chk(ptr, 21'h00A357);
    load_ptr(21'h01389A);
    tbl(TW_KEEP, 8'hAA);
    chk({13'h0000, hold[2]}, {13'h0000, 8'hAA});
    chk(ptr, 21'h01389A);
    tbl(TW_PRE_INC, 8'h34);
    chk({5'h00, hold[3], hold[2]}, {5'h00, 8'h34, 8'hAA});
    chk(ptr, 21'h01389B);
    tbl(TW_POST_DEC, 8'h77);
    chk({13'h0000, hold[3]}, {13'h0000, 8'h77});
    chk(ptr, 21'h01389A);
    load_ptr(21'h1FFFFF);
    tbl(TW_POST_INC, 8'hC3);
    chk({13'h0000, hold[7]}, {13'h0000, 8'hC3});
    chk(ptr, 21'h000000);
    $display("table write test done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the whole sequence needs well under 1 us; five times that means a hang
  initial begin
    #5000;
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    srst = 1'b1;
    instr = 16'h0000;
    two_word = 1'b0;
    bank_sel = 4'h0;
    rd = 8'h00;
    latch = 8'h00;
    ptr_load = 1'b0;
    ptr_data = 21'h000000;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    t_xor_literal();
    t_xor_register();
    t_test_skip();
    t_table_write();
    end_of_test();
  end
endmodule
`default_nettype wire
